// [logic/e1_rx_alarm_cfg.svh]
// register offsets, bit positions and detection counts for the
// receive alarm and status bank; assumes nothing else is included first
`ifndef E1_RX_ALARM_CFG_SVH
`define E1_RX_ALARM_CFG_SVH

`define ADDR_ALARM_STATUS_ONE     8'h06
`define ADDR_RECEIVE_INFORMATION  8'h08
`define ADDR_SYNCHRONIZER_STATUS  8'h1e
`define REG_RESET                 8'h00

// receive information bit positions
`define RI_TX_FULL    7
`define RI_TX_EMPTY   6
`define RI_JIT_TRIP   5
`define RI_RX_FULL    4
`define RI_RX_EMPTY   3
`define RI_CRC_RESYNC 2
`define RI_FAS_RESYNC 1
`define RI_CAS_RESYNC 0

// alarm status one bit positions
`define AS_SIG_ONES   7
`define AS_DIST_MF    6
`define AS_SIG_ZEROS  5
`define AS_SLIP       4
`define AS_UNF_ONES   3
`define AS_REMOTE     2
`define AS_CARRIER    1
`define AS_LOS        0

// frame structure
`define TS_SIGNALING  5'h10
`define TS_ALIGN      5'h00
`define BITPOS_DMA    3'h5
`define BITPOS_RAI    3'h2
`define FRAME_FIRST   4'h0
`define FRAME_LAST    4'hf
`define BITPOS_LAST   3'h7

// alarm thresholds
`define SIG_ONES_ZEROS   5'h03
`define DMA_RUN          2'h2
`define RAI_RUN          2'h3
`define UNF_WINDOW_LAST  9'h1ff
`define UNF_ZEROS        9'h003
`define CL_ZERO_RUN      8'hff
`define CL_WINDOW_LAST   8'hfe
`define CL_ONES          8'h20
`define CRC_BLOCK_LAST   10'h3e7
`define CRC_ERR_LIMIT    10'h393
`define FAS_ERR_RUN      2'h3
`define CAS_ERR_RUN      2'h2
`define JIT_MARGIN       8'h04

`endif

// [logic/e1_rx_alarm_pkg.sv]
// types shared by the receive alarm and status bank
// assumes e1_rx_alarm_cfg.svh supplies the numeric constants
package e1_rx_alarm_pkg;

   // one recovered receive bit with its position in the frame structure
   typedef struct packed {
      logic       valid;
      logic       data;
      logic [4:0] slot;
      logic [2:0] bitpos;
      logic [3:0] frame;
      logic       align;
   } rx_bit_s;

   // one-cycle events from framer, elastic stores and synchronizer
   typedef struct packed {
      logic tx_full;
      logic tx_empty;
      logic rx_full;
      logic rx_empty;
      logic fas_check;
      logic fas_error;
      logic cas_check;
      logic cas_error;
      logic crc_check;
      logic crc_error;
      logic crc_timeout;
      logic crc_found;
   } frame_event_s;

   // live synchronizer search levels
   typedef struct packed {
      logic fas_search;
      logic cas_search;
      logic crc_search;
   } sync_state_s;

   typedef logic [7:0] reg_byte_t;

endpackage

// [logic/e1_receive_alarm_status.sv]
// receive alarm detection and the three receive status registers
// assumes framer, stores and host port share clk_in; no synchronisers
`include "e1_rx_alarm_cfg.svh"
// Summary of operation
// [RULE1] transmit store full/empty flags on slips
// [RULE2] jitter trip within four bits of limit
// [RULE3] receive store full/empty flags on slips
// [RULE4] crc resync flag at 915 of 1000
// [RULE5] fas resync after three bad words
// [RULE6] cas resync after two bad words
// [RULE7] sync counter bits 5..2,0 in register
// [RULE8] search active flags read live
// [RULE9] counter steps on each search timeout
// [RULE10] counter clears on crc level sync
// [RULE11] counter clears while crc mode off
// [RULE12] counter wraps past maximum
// [RULE13] signaling all ones per multiframe
// [RULE14] signaling alarms kept in ccs mode
// [RULE15] signaling all zeros per multiframe
// [RULE16] distant mf alarm two multiframes
// [RULE17] unframed all ones per 512 bits
// [RULE18] remote alarm three non-align frames
// [RULE19] carrier loss 255 zeros, 32 ones clear
// [RULE20] loss of sync while not synchronized
// [RULE21] receive slip on repeat or delete
// [RULE22] latched bits masked write, then read
// [RULE23] synchronizer register live and read-only
// [RULE24] alarms gated onto interrupt output one
module e1_receive_alarm_status #(
   parameter int JIT_DEPTH = 32
) (
   // clock and reset
   input  wire logic                          clk_in,
   input  wire logic                          rst_in,
   // parallel control port
   input  wire logic [7:0]                    addr_in,
   input  wire logic                          wr_in,
   input  wire logic                          rd_in,
   input  wire e1_rx_alarm_pkg::reg_byte_t    wdata_in,
   output      e1_rx_alarm_pkg::reg_byte_t    rdata_out,
   // receive stream and framer events
   input  wire e1_rx_alarm_pkg::rx_bit_s      rx_bit_in,
   input  wire e1_rx_alarm_pkg::frame_event_s event_in,
   input  wire e1_rx_alarm_pkg::sync_state_s  sync_in,
   input  wire logic [7:0]                    jitter_fill_in,
   // configuration from elsewhere in the device
   input  wire logic                          crc_mode_enable_in,
   input  wire e1_rx_alarm_pkg::reg_byte_t    int_mask_one_in,
   // interrupt
   output      logic                          interrupt_out_one
);
   import e1_rx_alarm_pkg::*;
   function automatic logic at_bit(input rx_bit_s b, input logic [4:0] ts,
                                   input logic [2:0] pos);
      at_bit = b.valid && b.slot == ts && b.bitpos == pos;
   endfunction

   // set wins over the clear in the same cycle
   function automatic reg_byte_t sticky(input reg_byte_t held,
                                        input reg_byte_t set,
                                        input reg_byte_t clr);
      sticky = set | (held & ~clr);
   endfunction

   reg_byte_t  alarm_latch;
   reg_byte_t  alarm_status_one;
   reg_byte_t  info_latch;
   reg_byte_t  receive_information;
   reg_byte_t  synchronizer_status;
   reg_byte_t  alarm_set;
   reg_byte_t  info_set;
   logic       wr_alarm;
   logic       wr_info;
   logic [5:0] sync_count;

   // alarm levels
   logic sig_all_ones_alarm;
   logic sig_all_zeros_alarm;
   logic distant_mf_alarm;
   logic unframed_all_ones_alarm;
   logic remote_alarm_flag;
   logic carrier_loss_flag;
   assign wr_alarm = wr_in && addr_in == `ADDR_ALARM_STATUS_ONE;
   assign wr_info  = wr_in && addr_in == `ADDR_RECEIVE_INFORMATION;

   // ---- slot 16 content over one multiframe ----
   logic [4:0] sig_zero_count;
   logic       sig_one_seen;
   logic       ts16_bit;
   logic       mf_end;
   logic [4:0] next_zero_count;
   logic       next_one_seen;
   assign ts16_bit = rx_bit_in.valid && rx_bit_in.slot == `TS_SIGNALING;
   assign mf_end   = at_bit(rx_bit_in, `TS_SIGNALING, `BITPOS_LAST) &&
                     rx_bit_in.frame == `FRAME_LAST;
   assign next_zero_count = (!rx_bit_in.data &&
                             sig_zero_count != 5'h1f) ?
                            sig_zero_count + 5'h01 : sig_zero_count;
   assign next_one_seen = sig_one_seen | rx_bit_in.data;

   // evaluated regardless of cas or ccs signaling mode
   always_ff @(posedge clk_in) begin // RULE14
      if (rst_in) begin
         sig_zero_count      <= 5'h00;
         sig_one_seen        <= 1'b0;
         sig_all_ones_alarm  <= 1'b0;
         sig_all_zeros_alarm <= 1'b0;
      end else if (mf_end) begin
         sig_zero_count      <= 5'h00;
         sig_one_seen        <= 1'b0;
         sig_all_ones_alarm  <= next_zero_count < `SIG_ONES_ZEROS; // RULE13
         sig_all_zeros_alarm <= !next_one_seen; // RULE15
      end else if (ts16_bit) begin
         sig_zero_count <= next_zero_count;
         sig_one_seen   <= next_one_seen;
      end
   end

   // ---- distant multiframe alarm ----
   logic [1:0] dma_ones;
   logic [1:0] dma_zeros;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         dma_ones         <= 2'h0;
         dma_zeros        <= 2'h0;
         distant_mf_alarm <= 1'b0;
      end else if (at_bit(rx_bit_in, `TS_SIGNALING, `BITPOS_DMA) &&
                   rx_bit_in.frame == `FRAME_FIRST) begin
         if (rx_bit_in.data) begin
            dma_zeros <= 2'h0;
            if (dma_ones != `DMA_RUN)
               dma_ones <= dma_ones + 2'h1;
            if (dma_ones == `DMA_RUN - 2'h1)
               distant_mf_alarm <= 1'b1; // RULE16
         end else begin
            dma_ones <= 2'h0;
            if (dma_zeros != `DMA_RUN)
               dma_zeros <= dma_zeros + 2'h1;
            if (dma_zeros == `DMA_RUN - 2'h1)
               distant_mf_alarm <= 1'b0; // RULE16
         end
      end
   end

   // ---- remote alarm from non-align frames ----
   logic [1:0] rai_ones;
   logic [1:0] rai_zeros;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rai_ones          <= 2'h0;
         rai_zeros         <= 2'h0;
         remote_alarm_flag <= 1'b0;
      end else if (at_bit(rx_bit_in, `TS_ALIGN, `BITPOS_RAI) &&
                   !rx_bit_in.align) begin
         if (rx_bit_in.data) begin
            rai_zeros <= 2'h0;
            if (rai_ones != `RAI_RUN)
               rai_ones <= rai_ones + 2'h1;
            if (rai_ones == `RAI_RUN - 2'h1)
               remote_alarm_flag <= 1'b1; // RULE18
         end else begin
            rai_ones <= 2'h0;
            if (rai_zeros != `RAI_RUN)
               rai_zeros <= rai_zeros + 2'h1;
            if (rai_zeros == `RAI_RUN - 2'h1)
               remote_alarm_flag <= 1'b0; // RULE18
         end
      end
   end

   // ---- unframed all ones over 512-bit windows ----
   // windows are back to back, not sliding: cheaper, same verdict per window
   logic [8:0] unf_bits;
   logic [8:0] unf_zeros;
   logic [8:0] next_unf_zeros;
   assign next_unf_zeros = (!rx_bit_in.data && unf_zeros != 9'h1ff) ?
                           unf_zeros + 9'h001 : unf_zeros;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         unf_bits                <= 9'h000;
         unf_zeros               <= 9'h000;
         unframed_all_ones_alarm <= 1'b0;
      end else if (rx_bit_in.valid) begin
         unf_bits <= unf_bits + 9'h001;
         if (unf_bits == `UNF_WINDOW_LAST) begin
            unf_zeros               <= 9'h000;
            unframed_all_ones_alarm <= next_unf_zeros < `UNF_ZEROS; // RULE17
         end else begin
            unf_zeros <= next_unf_zeros;
         end
      end
   end

   // ---- carrier loss ----
   logic [7:0] cl_zero_run;
   logic [7:0] cl_bits;
   logic [7:0] cl_ones;
   logic [7:0] next_cl_ones;
   assign next_cl_ones = (rx_bit_in.data && cl_ones != 8'hff) ?
                         cl_ones + 8'h01 : cl_ones;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cl_zero_run       <= 8'h00;
         cl_bits           <= 8'h00;
         cl_ones           <= 8'h00;
         carrier_loss_flag <= 1'b0;
      end else if (rx_bit_in.valid) begin
         if (rx_bit_in.data)
            cl_zero_run <= 8'h00;
         else if (cl_zero_run != `CL_ZERO_RUN)
            cl_zero_run <= cl_zero_run + 8'h01;
         if (!rx_bit_in.data && cl_zero_run == `CL_ZERO_RUN - 8'h01)
            carrier_loss_flag <= 1'b1; // RULE19
         // clear window restarts each 255 bits while in loss
         if (cl_bits == `CL_WINDOW_LAST || !carrier_loss_flag) begin
            cl_bits <= 8'h00;
            cl_ones <= 8'h00;
            if (carrier_loss_flag && next_cl_ones >= `CL_ONES)
               carrier_loss_flag <= 1'b0; // RULE19
         end else begin
            cl_bits <= cl_bits + 8'h01;
            cl_ones <= next_cl_ones;
         end
      end
   end

   // ---- resync criteria ----
   logic [1:0] fas_err_run;
   logic [1:0] cas_err_run;
   logic [9:0] crc_words;
   logic [9:0] crc_errs;
   logic       fas_resync;
   logic       cas_resync;
   logic       crc_resync;
   logic [9:0] next_crc_errs;
   assign next_crc_errs = crc_errs + {9'h000, event_in.crc_error};

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         fas_err_run <= 2'h0;
         cas_err_run <= 2'h0;
         crc_words   <= 10'h000;
         crc_errs    <= 10'h000;
         fas_resync  <= 1'b0;
         cas_resync  <= 1'b0;
         crc_resync  <= 1'b0;
      end else begin
         fas_resync <= 1'b0;
         cas_resync <= 1'b0;
         crc_resync <= 1'b0;
         if (event_in.fas_check) begin
            fas_err_run <= event_in.fas_error &&
                           fas_err_run != `FAS_ERR_RUN - 2'h1 ?
                           fas_err_run + 2'h1 : 2'h0;
            fas_resync  <= event_in.fas_error &&
                           fas_err_run == `FAS_ERR_RUN - 2'h1; // RULE5
         end
         if (event_in.cas_check) begin
            cas_err_run <= event_in.cas_error &&
                           cas_err_run != `CAS_ERR_RUN - 2'h1 ?
                           cas_err_run + 2'h1 : 2'h0;
            cas_resync  <= event_in.cas_error &&
                           cas_err_run == `CAS_ERR_RUN - 2'h1; // RULE6
         end
         if (event_in.crc_check) begin
            if (crc_words == `CRC_BLOCK_LAST) begin
               crc_words  <= 10'h000;
               crc_errs   <= 10'h000;
               crc_resync <= next_crc_errs >= `CRC_ERR_LIMIT; // RULE4
            end else begin
               crc_words <= crc_words + 10'h001;
               crc_errs  <= next_crc_errs;
            end
         end
      end
   end

   // ---- crc4 sync counter ----
   always_ff @(posedge clk_in) begin
      if (rst_in || !crc_mode_enable_in)
         sync_count <= 6'h00; // RULE11
      else if (event_in.crc_found)
         sync_count <= 6'h00; // RULE10
      else if (event_in.crc_timeout)
         sync_count <= sync_count + 6'h01; // RULE9 RULE12
   end

   // ---- latched registers ----
   always_comb begin
      alarm_set = 8'h00;
      alarm_set[`AS_SIG_ONES]  = sig_all_ones_alarm;
      alarm_set[`AS_DIST_MF]   = distant_mf_alarm;
      alarm_set[`AS_SIG_ZEROS] = sig_all_zeros_alarm;
      alarm_set[`AS_SLIP] = event_in.rx_full | event_in.rx_empty; // RULE21
      alarm_set[`AS_UNF_ONES]  = unframed_all_ones_alarm;
      alarm_set[`AS_REMOTE]    = remote_alarm_flag;
      alarm_set[`AS_CARRIER]   = carrier_loss_flag;
      alarm_set[`AS_LOS]       = sync_in.fas_search; // RULE20
   end

   always_comb begin
      info_set = 8'h00;
      info_set[`RI_TX_FULL]    = event_in.tx_full; // RULE1
      info_set[`RI_TX_EMPTY]   = event_in.tx_empty; // RULE1
      info_set[`RI_JIT_TRIP]   = jitter_fill_in + `JIT_MARGIN >=
                                 8'(JIT_DEPTH); // RULE2
      info_set[`RI_RX_FULL]    = event_in.rx_full; // RULE3
      info_set[`RI_RX_EMPTY]   = event_in.rx_empty; // RULE3
      info_set[`RI_CRC_RESYNC] = crc_resync;
      info_set[`RI_FAS_RESYNC] = fas_resync;
      info_set[`RI_CAS_RESYNC] = cas_resync;
   end

   // mask write copies selected latched bits into the read image and clears
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         alarm_latch      <= `REG_RESET;
         alarm_status_one <= `REG_RESET;
      end else begin
         alarm_latch <= sticky(alarm_latch, alarm_set,
                               wr_alarm ? wdata_in : 8'h00); // RULE22
         if (wr_alarm)
            alarm_status_one <= (alarm_latch & wdata_in) |
                                (alarm_status_one & ~wdata_in); // RULE22
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         info_latch          <= `REG_RESET;
         receive_information <= `REG_RESET;
      end else begin
         info_latch <= sticky(info_latch, info_set,
                              wr_info ? wdata_in : 8'h00); // RULE22
         if (wr_info)
            receive_information <= (info_latch & wdata_in) |
                                   (receive_information & ~wdata_in);
      end
   end

   assign synchronizer_status = {sync_count[5:2], sync_count[0], // RULE7
                                 sync_in.fas_search, sync_in.cas_search,
                                 sync_in.crc_search}; // RULE8 RULE23

   // ---- read port ----
   always_ff @(posedge clk_in) begin
      if (rst_in)
         rdata_out <= `REG_RESET;
      else if (rd_in) begin
         case (addr_in)
            `ADDR_ALARM_STATUS_ONE:    rdata_out <= alarm_status_one;
            `ADDR_RECEIVE_INFORMATION: rdata_out <= receive_information;
            `ADDR_SYNCHRONIZER_STATUS: rdata_out <= synchronizer_status;
            default:                   rdata_out <= 8'h00;
         endcase
      end
   end

   // ---- interrupt ----
   always_ff @(posedge clk_in) begin
      if (rst_in)
         interrupt_out_one <= 1'b0;
      else
         interrupt_out_one <= |(alarm_latch & int_mask_one_in); // RULE24
   end

endmodule

// [verif/e1_line_model.sv]
// far-end e1 line model: framed receive stream, one bit every cycle
// assumes the bank takes each cycle out of reset as one valid bit
module e1_line_model
   import e1_rx_alarm_pkg::*;
(
   // clock and reset
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   // pattern: 0 all ones, 1 all zeros, 2 mixed
   input  wire logic [1:0]               mode_in,
   // recovered stream
   output      e1_rx_alarm_pkg::rx_bit_s rx_bit_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] bitpos;
   logic [4:0] slot;
   logic [3:0] frame;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         bitpos <= 3'h0;
         slot   <= 5'h00;
         frame  <= 4'h0;
      end else begin
         bitpos <= bitpos + 3'h1;
         if (bitpos == 3'h7) slot <= slot + 5'h01;
         if (bitpos == 3'h7 && slot == 5'h1f) frame <= frame + 4'h1;
      end
   end

   // mixed pattern keeps the alarm bit positions at zero
   always_comb begin
      rx_bit_out.valid  = !rst_in;
      rx_bit_out.slot   = slot;
      rx_bit_out.bitpos = bitpos;
      rx_bit_out.frame  = frame;
      rx_bit_out.align  = !frame[0];
      case (mode_in)
         2'h0: rx_bit_out.data = 1'b1;
         2'h1: rx_bit_out.data = 1'b0;
         default: rx_bit_out.data = (bitpos[1:0] != 2'h2) && (bitpos != 3'h5);
      endcase
   end
endmodule

// [verif/e1_rx_alarm_monitor.sv]
// port-level checker for the receive alarm and status bank
// sees only the bank's ports; bound in below the module
module e1_rx_alarm_monitor
   import e1_rx_alarm_pkg::*;
#(
   parameter int JIT_DEPTH = 32
) (
   // clock and reset
   input wire logic                          clk_in,
   input wire logic                          rst_in,
   // control port
   input wire logic [7:0]                    addr_in,
   input wire logic                          wr_in,
   input wire logic                          rd_in,
   input wire e1_rx_alarm_pkg::reg_byte_t    wdata_in,
   input wire e1_rx_alarm_pkg::reg_byte_t    rdata_out,
   // stream, events and levels
   input wire e1_rx_alarm_pkg::rx_bit_s      rx_bit_in,
   input wire e1_rx_alarm_pkg::frame_event_s event_in,
   input wire e1_rx_alarm_pkg::sync_state_s  sync_in,
   input wire logic [7:0]                    jitter_fill_in,
   input wire logic                          crc_mode_enable_in,
   input wire e1_rx_alarm_pkg::reg_byte_t    int_mask_one_in,
   input wire logic                          interrupt_out_one
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] JIT_TRIP = 8'(JIT_DEPTH - 4);
   logic [5:0] cnt;

   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // shadow of the search counter; same-cycle step and clear not judged
   always_ff @(posedge clk_in) begin
      if (rst_in || event_in.crc_found || !crc_mode_enable_in) cnt <= 6'h00;
      else if (event_in.crc_timeout) cnt <= cnt + 6'h01;
   end

   unmapped_read_a: assert property (
      rd_in && !(addr_in inside {8'h06, 8'h08, 8'h1e}) |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   read_hold_a: assert property (
      !rd_in |=> $stable(rdata_out)) else $error("read data moved");
   search_live_a: assert property (
      rd_in && addr_in == 8'h1e |=> rdata_out[2:0] == $past(sync_in))
      else $error("search flags not live");
   sync_count_a: assert property (
      rd_in && addr_in == 8'h1e && !event_in.crc_timeout && !event_in.crc_found
      |=> rdata_out[7:3] == {$past(cnt[5:2]), $past(cnt[0])})
      else $error("sync counter wrong");
   int_gate_a: assert property (
      int_mask_one_in == 8'h00 |=> !interrupt_out_one)
      else $error("masked interrupt raised");
   los_latch_a: assert property (
      sync_in.fas_search [*4] ##0 (wr_in && addr_in == 8'h06 && wdata_in[0])
      ##1 (rd_in && addr_in == 8'h06) |=> rdata_out[0])
      else $error("loss of sync missing");
   tx_full_a: assert property (
      event_in.tx_full ##1 !wr_in
      ##1 (wr_in && addr_in == 8'h08 && wdata_in[7])
      ##1 (rd_in && addr_in == 8'h08) |=> rdata_out[7])
      else $error("tx full flag missing");
   rx_full_a: assert property (
      event_in.rx_full ##1 !wr_in
      ##1 (wr_in && addr_in == 8'h08 && wdata_in[4])
      ##1 (rd_in && addr_in == 8'h08) |=> rdata_out[4])
      else $error("rx full flag missing");
   jit_trip_a: assert property (
      (jitter_fill_in >= JIT_TRIP) [*3] ##0
      (wr_in && addr_in == 8'h08 && wdata_in[5])
      ##1 (rd_in && addr_in == 8'h08) |=> rdata_out[5])
      else $error("jitter trip missing");
endmodule

bind e1_receive_alarm_status
   e1_rx_alarm_monitor #(.JIT_DEPTH(JIT_DEPTH)) u_mon (
   .clk_in, .rst_in, .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out,
   .rx_bit_in, .event_in, .sync_in, .jitter_fill_in, .crc_mode_enable_in,
   .int_mask_one_in, .interrupt_out_one
);

// [verif/tb.sv]
// self-checking bench for the receive alarm and status bank
// assumes the line model feeds the stream; host port driven here
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import e1_rx_alarm_pkg::*;
   localparam int JD = 20;
   logic         clk_in, rst_in, wr_in, rd_in, crc_mode_enable_in;
   logic         interrupt_out_one;
   logic [7:0]   addr_in, jitter_fill_in;
   logic [1:0]   mode;
   logic [5:0]   cnt;
   logic [31:0]  seed;
   reg_byte_t    wdata_in, rdata_out, int_mask_one_in, seen;
   rx_bit_s      rx_bit_in;
   frame_event_s event_in;
   sync_state_s  sync_in;
   int           err_total, checked, n, i, k;
   logic [7:0]   adr [4] = '{8'h06, 8'h08, 8'h1e, 8'h05};
   logic [11:0]  evs [4] = '{12'h800, 12'h400, 12'h200, 12'h100};
   logic [7:0]   evb [4] = '{8'h80, 8'h40, 8'h10, 8'h08};
   logic [7:0]   exps [3] = '{8'hcc, 8'h22, 8'h00};

`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
   $display("unexpected %s exp %h got %h", nm, e, s); end end

   e1_line_model u_e1_line_model (.clk_in, .rst_in, .mode_in(mode),
      .rx_bit_out(rx_bit_in));
   e1_receive_alarm_status #(.JIT_DEPTH(JD)) u_e1_receive_alarm_status (
      .clk_in, .rst_in, .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out,
      .rx_bit_in, .event_in, .sync_in, .jitter_fill_in, .crc_mode_enable_in,
      .int_mask_one_in, .interrupt_out_one);

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic reg_byte_t exp_ssr(logic [5:0] c, sync_state_s s);
      return {c[5:2], c[0], s};
   endfunction

   // mask write then read, as the latched registers need
   task automatic access(input logic [7:0] a, input reg_byte_t m);
      @(posedge clk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= m;
      @(posedge clk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 seen = rdata_out;
   endtask

   task automatic pulse(input frame_event_s ev);
      @(posedge clk_in);
      event_in <= ev;
      @(posedge clk_in);
      event_in <= '0;
   endtask

   task automatic wrap_up();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   // whole run is near 42000 cycles
   initial begin
      repeat (90000) @(posedge clk_in);
      err_total++;
      wrap_up();
   end

   initial begin
      rst_in = 1'b1;
      {wr_in, rd_in, addr_in, wdata_in, event_in, sync_in} = '0;
      {jitter_fill_in, int_mask_one_in, cnt, err_total, checked} = '0;
      crc_mode_enable_in = 1'b1;
      mode = 2'h2;
      seed = 32'h00010f47;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      for (k = 0; k < 4; k++) begin
         access(adr[k], 8'hff);
         `CHK("reset value", 8'h00, seen)
      end
      for (k = 0; k < 4; k++) begin
         pulse(evs[k]);
         access(8'h08, 8'h00);
         `CHK("masked hold", 8'h00, seen)
         access(8'h08, 8'hff);
         `CHK("store flag", evb[k], seen)
         access(8'h08, 8'hff);
         `CHK("flag cleared", 8'h00, seen)
      end
      pulse(12'ha00);
      access(8'h08, 8'hff);
      `CHK("both full", 8'h90, seen)
      access(8'h06, 8'hff);
      `CHK("slip", 8'h10, seen)
      pulse(12'h0c0);
      pulse(12'h0c0);
      pulse(12'h080);
      pulse(12'h0c0);
      pulse(12'h0c0);
      access(8'h08, 8'hff);
      `CHK("fas two", 8'h00, seen)
      pulse(12'h0c0);
      access(8'h08, 8'hff);
      `CHK("fas three", 8'h02, seen)
      pulse(12'h030);
      pulse(12'h020);
      pulse(12'h030);
      access(8'h08, 8'hff);
      `CHK("cas one", 8'h00, seen)
      pulse(12'h030);
      access(8'h08, 8'hff);
      `CHK("cas two", 8'h01, seen)
      for (k = 0; k < 2; k++) begin
         for (i = 0; i < 1000; i++) pulse((i < 914 + k) ? 12'h00c : 12'h008);
         access(8'h08, 8'hff);
         `CHK("crc resync", (k == 1) ? 8'h04 : 8'h00, seen)
      end
      for (k = 0; k < 2; k++) begin
         jitter_fill_in <= 8'(JD - 4 - k);
         repeat (4) @(posedge clk_in);
         access(8'h08, 8'hff);
         access(8'h08, 8'hff);
         `CHK("jitter trip", (k == 0) ? 8'h20 : 8'h00, seen)
      end
      for (i = 0; i < 6; i++) begin
         sync_in <= sync_state_s'(rnd());
         n = (i == 0) ? 66 : rnd() % 70;
         repeat (n) pulse(12'h002);
         cnt = cnt + 6'(n);
         if (i == 2) begin
            pulse(12'h001);
            cnt = 6'h00;
         end
         if (i == 4) begin
            @(posedge clk_in) crc_mode_enable_in <= 1'b0;
            @(posedge clk_in) crc_mode_enable_in <= 1'b1;
            cnt = 6'h00;
         end
         access(8'h1e, reg_byte_t'(rnd()));
         `CHK("sync status", exp_ssr(cnt, sync_in), seen)
      end
      sync_in <= '0;
      // three multiframes let every per-multiframe alarm settle
      for (k = 0; k < 3; k++) begin
         mode <= 2'(k);
         repeat (12400) @(posedge clk_in);
         access(8'h06, 8'hff);
         access(8'h06, 8'hff);
         `CHK("line alarms", exps[k], seen)
         if (k == 0) begin
            int_mask_one_in <= 8'h80;
            repeat (3) @(posedge clk_in);
            #1;
            `CHK("irq enabled", 1'b1, interrupt_out_one)
            int_mask_one_in <= 8'h01;
            repeat (3) @(posedge clk_in);
            #1;
            `CHK("irq gated", 1'b0, interrupt_out_one)
            int_mask_one_in <= 8'h00;
         end
      end
      sync_in <= 3'b100;
      repeat (4) @(posedge clk_in);
      access(8'h06, 8'hff);
      access(8'h06, 8'hff);
      `CHK("loss of sync", 8'h01, seen)
      wrap_up();
   end
endmodule
